/* rtl/scp_pkg.sv */
// constants, codes and carriers of the core instruction pipeline
package scp_pkg;
  localparam int ADDR_W = 32;
  localparam int BLOCK_BYTES = 16;
  localparam int OFS_W = 4;
  localparam int INSN_BYTES = 2;
  localparam int INSN_SH = 1;
  localparam int SLOTS = BLOCK_BYTES / INSN_BYTES;
  localparam int SLOT_W = 3;
  localparam int BLOCK_BITS = BLOCK_BYTES * 8;
  localparam int INSN_W = 16;
  localparam int ICACHE_BYTES = 32 * 1024;
  localparam int IC_SETS = ICACHE_BYTES / BLOCK_BYTES;
  localparam int IC_IDX_W = 11;
  localparam int TAG_W = ADDR_W - IC_IDX_W - OFS_W;
  localparam int IMM_W = 10;
  localparam int N_DEC = 3;
  localparam int DEC0_MAX_UOPS = 4;
  localparam int ISSUE_MAX = DEC0_MAX_UOPS + N_DEC - 1;
  localparam int GRP_W = 3;
  localparam int N_PORTS = 5;
  localparam int BR_PORT = 4;
  localparam int RETIRE_MAX = 3;
  localparam int RET_W = 2;
  localparam int ROB_N = 16;
  localparam int ROB_W = 4;
  localparam int ROB_CNT_W = 5;
  localparam int BTT_N = 64;
  localparam int BTT_W = 6;
  localparam int LINE_BYTES = 64;
  localparam int LINE_OFS_W = 6;
  localparam int LINE_W = ADDR_W - LINE_OFS_W;
  localparam int TLB_ENTRIES = 128;
  localparam logic [ADDR_W-1:0] RESET_PC = 32'h0000_0000;
  localparam logic [2:0] UOP_ONE = 3'h1;
  localparam logic [2:0] UOP_TWO = 3'h2;
  localparam logic [1:0] CTR_MIN = 2'h0;
  localparam logic [1:0] CTR_WEAK_NT = 2'h1;
  localparam logic [1:0] CTR_WEAK_TK = 2'h2;
  localparam logic [1:0] CTR_MAX = 2'h3;

  typedef enum logic [3:0] {
    CLS_ALU = 4'h0, CLS_LDOP = 4'h1, CLS_VLD = 4'h2, CLS_ST = 4'h3, CLS_PUSH = 4'h4,
    CLS_POP = 4'h5, CLS_CALL = 4'h6, CLS_RET = 4'h7, CLS_BR = 4'h8, CLS_CPLX = 4'h9
  } scp_cls_type;
  typedef enum logic [1:0] {
    K_ALU = 2'h0, K_LOAD = 2'h1, K_STORE = 2'h2, K_BR = 2'h3
  } scp_kind_type;
  typedef enum logic [1:0] {F_RUN = 2'b01, F_MISS = 2'b10} scp_fstate_type;

  // per-port uop kind; parity mask bit0 allows even entries, bit1 odd entries
  localparam scp_kind_type PORT_KIND [N_PORTS] = '{K_ALU, K_ALU, K_LOAD, K_STORE, K_BR};
  localparam logic [1:0] PORT_PAR [N_PORTS] = '{2'h1, 2'h2, 2'h3, 2'h3, 2'h3};

  typedef struct packed {
    logic [3:0] cls;
    logic spare;
    logic taken;
    logic [IMM_W-1:0] imm;
  } scp_insn_type;
  typedef struct packed {
    logic [3:0] cls;
    logic [2:0] nuops;
    logic taken;
    logic [IMM_W-1:0] imm;
  } scp_pdec_type;
  typedef struct packed {
    scp_kind_type kind;
    logic dep;
    logic act_tk;
    logic pred_tk;
    logic [ADDR_W-1:0] pc;
    logic [ADDR_W-1:0] tgt;
    logic [ADDR_W-1:0] pred_tgt;
  } scp_uop_type;
  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
  } scp_req_type;
endpackage : scp_pkg

/* rtl/scp_core.sv */
// instruction flow of the out-of-order core: fetch, decode, issue, dispatch, retire
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - a fetch miss pulls only the aligned block holding the pc from memory
// - fetch works on aligned 16-byte blocks, one block per cycle
// - target at offset 14 yields two useful bytes, the rest next cycles
// - the 32KB instruction cache keeps predecoded instructions, not raw bytes
// - decoder zero takes one instruction of up to four uops per cycle
// - decoders one and two take only single-uop instructions
// - several uops issue per cycle in strict program order
// - push, pop, call and return lose their stack pointer adjust uops
// - store address and store data fuse into one store uop, every type
// - load fuses with its following operation, vector loads never fuse
// - prediction mixes static, dynamic and a target table indexed by address
// - data prefetcher pushes lines into the second-level cache unasked
// - data fills move 64 bytes; translation buffers have 128 entries
// - a uop waits in the station until operands and a port are ready
// - at most five uops dispatch per cycle, in any order
// - completed uops wait in the commit buffer and retire in order
// - no more than three uops retire per cycle
module scp_core (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // instruction block fill
  output var scp_pkg::scp_req_type ifill_req,
  input wire logic ifill_valid,
  input wire logic [scp_pkg::BLOCK_BITS-1:0] ifill_data,
  // data miss stream and second-level prefetch
  input wire logic dmiss_valid,
  input wire logic [scp_pkg::ADDR_W-1:0] dmiss_addr,
  output var scp_pkg::scp_req_type l2_prefetch,
  // retirement status
  output logic [scp_pkg::RET_W-1:0] retire_count,
  output logic [scp_pkg::ADDR_W-1:0] retire_pc,
  output logic flush_pulse
);
  import scp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [ADDR_W-1:0] simm(logic [IMM_W-1:0] i);
    return {{(ADDR_W-IMM_W-INSN_SH){i[IMM_W-1]}}, i, {INSN_SH{1'b0}}};
  endfunction : simm

  function automatic scp_pdec_type pdec(scp_insn_type w);
    scp_pdec_type p;
    p.cls = w.cls;
    p.taken = w.taken;
    p.imm = w.imm;
    case (w.cls)
      CLS_VLD, CLS_CALL, CLS_RET: p.nuops = UOP_TWO;
      CLS_CPLX: p.nuops = {1'b0, w.imm[1:0]} + UOP_ONE;
      default: p.nuops = UOP_ONE;
    endcase
    return p;
  endfunction : pdec

  function automatic scp_uop_type mk_uop(scp_pdec_type e, logic [ADDR_W-1:0] ipc, int j,
                                         logic ptk, logic [ADDR_W-1:0] ptg);
    scp_uop_type o;
    o = '0;
    o.pc = ipc;
    o.tgt = ipc + simm(e.imm);
    o.dep = (j != 0);
    o.act_tk = (e.cls == CLS_BR) ? e.taken : 1'b1;
    o.pred_tk = ptk;
    o.pred_tgt = ptg;
    case (e.cls)
      CLS_LDOP, CLS_POP: o.kind = K_LOAD;
      CLS_ST, CLS_PUSH: o.kind = K_STORE;
      CLS_VLD: o.kind = (j == 0) ? K_LOAD : K_ALU;
      CLS_CALL: o.kind = (j == 0) ? K_STORE : K_BR;
      CLS_RET: o.kind = (j == 0) ? K_LOAD : K_BR;
      CLS_BR: o.kind = K_BR;
      default: o.kind = K_ALU;
    endcase
    return o;
  endfunction : mk_uop

  ////////////////////////////////////////////////////////////////////////////////
  // declarations

  scp_fstate_type fst_q;
  logic [ADDR_W-1:0] pc_q;
  scp_req_type ifill_req_q;
  logic [IC_SETS-1:0] ic_valid_q;
  logic [TAG_W-1:0] ic_tag_q [IC_SETS];
  scp_pdec_type [SLOTS-1:0] ic_line_q [IC_SETS];
  logic [IC_IDX_W-1:0] rd_idx;
  logic [IC_IDX_W-1:0] fill_idx;
  logic hit;
  scp_uop_type ub [ISSUE_MAX];
  logic [GRP_W-1:0] grp_u;
  logic [ADDR_W-1:0] nxt_pc;
  logic room;
  logic issue;
  logic [BTT_N-1:0] btt_v_q;
  logic [ADDR_W-1:0] btt_pc_q [BTT_N];
  logic [ADDR_W-1:0] btt_tgt_q [BTT_N];
  logic [1:0] btt_ctr_q [BTT_N];
  logic [BTT_W-1:0] bb;
  logic [ROB_W-1:0] head_q;
  logic [ROB_W-1:0] tail_q;
  logic [ROB_CNT_W-1:0] cnt_q;
  logic [ROB_N-1:0] rob_v;
  logic [ROB_N-1:0] rob_done;
  logic [ROB_N-1:0] rs_v;
  logic [ROB_N-1:0] rdy;
  logic [ROB_N-1:0] disp;
  logic [ROB_N-1:0] cmpl;
  scp_uop_type rob_uop [ROB_N];
  logic [ROB_N-1:0] gnt [N_PORTS];
  logic [N_PORTS-1:0] exv;
  logic [ROB_W-1:0] exix [N_PORTS];
  logic [RET_W-1:0] ret_n;
  scp_uop_type bu;
  logic br_ok;
  logic br_flush;
  logic [ADDR_W-1:0] br_fix;
  logic [ROB_W-1:0] br_age;
  logic [LINE_W-1:0] dline;
  logic [LINE_W-1:0] last_line_q;
  scp_req_type l2_pf_q;
  logic [RET_W-1:0] retire_count_q;
  logic [ADDR_W-1:0] retire_pc_q;
  logic flush_q;

  ////////////////////////////////////////////////////////////////////////////////
  // fetch and predecoded cache

  assign rd_idx = pc_q[OFS_W +: IC_IDX_W];
  assign fill_idx = ifill_req_q.addr[OFS_W +: IC_IDX_W];
  assign hit = (fst_q == F_RUN) && ic_valid_q[rd_idx]
               && (ic_tag_q[rd_idx] == pc_q[ADDR_W-1 -: TAG_W]);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      fst_q <= F_RUN;
      pc_q <= RESET_PC;
      ifill_req_q <= '0;
    end else begin
      ifill_req_q.valid <= 1'b0;
      if (br_flush) begin
        pc_q <= br_fix;
      end
      unique case (fst_q)
        F_RUN: begin
          if (!br_flush && hit && issue) begin
            pc_q <= nxt_pc;
          end else if (!br_flush && !hit) begin
            fst_q <= F_MISS;
            ifill_req_q.valid <= 1'b1;
            ifill_req_q.addr <= {pc_q[ADDR_W-1:OFS_W], {OFS_W{1'b0}}};
          end
        end
        F_MISS: begin
          if (ifill_valid) begin
            fst_q <= F_RUN;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ic_valid_q <= '0;
    end else if (fst_q == F_MISS && ifill_valid) begin
      ic_valid_q[fill_idx] <= 1'b1;
    end
  end

  // predecode once at fill so the decoders see uop counts, not bytes
  always_ff @(posedge mclk) begin
    if (fst_q == F_MISS && ifill_valid) begin
      ic_tag_q[fill_idx] <= ifill_req_q.addr[ADDR_W-1 -: TAG_W];
      for (int k = 0; k < SLOTS; k++) begin
        ic_line_q[fill_idx][k] <= pdec(ifill_data[k*INSN_W +: INSN_W]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // three decoders, prediction and in-order issue group

  always_comb begin
    logic [OFS_W-1:0] s;
    int u;
    logic stop;
    scp_pdec_type e;
    logic [ADDR_W-1:0] ipc;
    logic ptk;
    logic [ADDR_W-1:0] ptg;
    logic [BTT_W-1:0] bi;
    s = '0;
    u = 0;
    stop = 1'b0;
    e = '0;
    ipc = pc_q;
    ptk = 1'b0;
    ptg = pc_q;
    bi = '0;
    nxt_pc = pc_q;
    for (int k = 0; k < ISSUE_MAX; k++) begin
      ub[k] = '0;
    end
    for (int k = 0; k < N_DEC; k++) begin
      s = {1'b0, pc_q[OFS_W-1:INSN_SH]} + OFS_W'(k);
      stop = stop || (s >= OFS_W'(SLOTS));
      if (!stop) begin
        e = ic_line_q[rd_idx][s[SLOT_W-1:0]];
        stop = (k != 0) && (e.nuops != UOP_ONE);
      end
      if (!stop) begin
        ipc = pc_q + ADDR_W'(k * INSN_BYTES);
        ptg = ipc + simm(e.imm);
        ptk = 1'b0;
        bi = ipc[INSN_SH +: BTT_W];
        if (e.cls == CLS_BR || e.cls == CLS_CALL || e.cls == CLS_RET) begin
          if (btt_v_q[bi] && btt_pc_q[bi] == ipc) begin
            ptk = btt_ctr_q[bi][1];
            ptg = btt_tgt_q[bi];
          end else begin
            ptk = (e.cls == CLS_CALL) || (e.cls == CLS_BR && e.imm[IMM_W-1]);
          end
        end
        for (int j = 0; j < DEC0_MAX_UOPS; j++) begin
          if (j < int'(e.nuops) && u < ISSUE_MAX) begin
            ub[u] = mk_uop(e, ipc, j, ptk, ptg);
            u = u + 1;
          end
        end
        nxt_pc = ptk ? ptg : ipc + ADDR_W'(INSN_BYTES);
        stop = ptk;
      end
    end
    grp_u = GRP_W'(u);
  end

  // the whole group waits rather than splitting, so no uop is lost or repeated
  assign room = (ROB_CNT_W'(ROB_N) - cnt_q) >= ROB_CNT_W'(grp_u);
  assign issue = hit && room && !br_flush;

  ////////////////////////////////////////////////////////////////////////////////
  // commit buffer entries with their operand wait station slots

  for (genvar i = 0; i < ROB_N; i++) begin : g_ent
    logic v_q;
    logic rs_q;
    logic done_q;
    scp_uop_type uop_q;
    logic [ROB_W-1:0] age;
    logic [ROB_W-1:0] aoff;
    logic alloc;
    logic kill;
    assign age = ROB_W'(i) - head_q;
    assign aoff = ROB_W'(i) - tail_q;
    assign alloc = issue && (aoff < ROB_W'(grp_u));
    assign kill = br_flush && v_q && (age > br_age);
    assign rob_v[i] = v_q;
    assign rob_done[i] = done_q;
    assign rs_v[i] = rs_q;
    assign rob_uop[i] = uop_q;
    assign rdy[i] = rs_v[i] && (!uop_q.dep || rob_done[ROB_W'(i + ROB_N - 1)]);
    always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
        v_q <= 1'b0;
        rs_q <= 1'b0;
        done_q <= 1'b0;
      end else if (kill || (v_q && age < ROB_W'(ret_n))) begin
        v_q <= 1'b0;
        rs_q <= 1'b0;
      end else if (alloc) begin
        v_q <= 1'b1;
        rs_q <= 1'b1;
        done_q <= 1'b0;
      end else begin
        if (disp[i]) begin
          rs_q <= 1'b0;
        end
        if (cmpl[i]) begin
          done_q <= 1'b1;
        end
      end
    end
    always_ff @(posedge mclk) begin
      if (alloc) begin
        uop_q <= ub[aoff[GRP_W-1:0]];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // dispatch ports: one uop each, lowest-index first, not program order

  for (genvar p = 0; p < N_PORTS; p++) begin : g_port
    logic [ROB_W-1:0] pick;
    logic found;
    logic ex_v_q;
    logic [ROB_W-1:0] ex_ix_q;
    always_comb begin
      pick = '0;
      found = 1'b0;
      for (int i = ROB_N - 1; i >= 0; i--) begin
        if (rdy[i] && rob_uop[i].kind == PORT_KIND[p] && PORT_PAR[p][i % 2]) begin
          pick = ROB_W'(i);
          found = 1'b1;
        end
      end
    end
    assign gnt[p] = found ? (ROB_N'(1) << pick) : '0;
    assign exv[p] = ex_v_q;
    assign exix[p] = ex_ix_q;
    always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
        ex_v_q <= 1'b0;
        ex_ix_q <= '0;
      end else begin
        ex_v_q <= found;
        ex_ix_q <= pick;
      end
    end
  end

  // a completion for an entry already killed is dropped by the valid gate
  always_comb begin
    disp = '0;
    cmpl = '0;
    for (int p = 0; p < N_PORTS; p++) begin
      disp = disp | gnt[p];
      if (exv[p]) begin
        cmpl[exix[p]] = 1'b1;
      end
    end
    cmpl = cmpl & rob_v;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // branch resolution and target table training

  assign bu = rob_uop[exix[BR_PORT]];
  assign br_ok = exv[BR_PORT] && rob_v[exix[BR_PORT]];
  assign br_flush = br_ok && ((bu.pred_tk != bu.act_tk)
                              || (bu.act_tk && bu.pred_tgt != bu.tgt));
  assign br_fix = bu.act_tk ? bu.tgt : bu.pc + ADDR_W'(INSN_BYTES);
  assign br_age = exix[BR_PORT] - head_q;
  assign bb = bu.pc[INSN_SH +: BTT_W];

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      btt_v_q <= '0;
    end else if (br_ok) begin
      btt_v_q[bb] <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (br_ok) begin
      btt_pc_q[bb] <= bu.pc;
      btt_tgt_q[bb] <= bu.tgt;
      if (!btt_v_q[bb] || btt_pc_q[bb] != bu.pc) begin
        btt_ctr_q[bb] <= bu.act_tk ? CTR_WEAK_TK : CTR_WEAK_NT;
      end else if (bu.act_tk && btt_ctr_q[bb] != CTR_MAX) begin
        btt_ctr_q[bb] <= btt_ctr_q[bb] + 2'h1;
      end else if (!bu.act_tk && btt_ctr_q[bb] != CTR_MIN) begin
        btt_ctr_q[bb] <= btt_ctr_q[bb] - 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // in-order retirement and buffer pointers

  always_comb begin
    logic go;
    logic [ROB_W-1:0] ix;
    go = 1'b1;
    ix = head_q;
    ret_n = '0;
    for (int k = 0; k < RETIRE_MAX; k++) begin
      ix = head_q + ROB_W'(k);
      go = go && rob_v[ix] && rob_done[ix];
      if (go) begin
        ret_n = ret_n + RET_W'(1);
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      head_q <= '0;
      tail_q <= '0;
      cnt_q <= '0;
    end else begin
      head_q <= head_q + ROB_W'(ret_n);
      if (br_flush) begin
        tail_q <= exix[BR_PORT] + ROB_W'(1);
        cnt_q <= ROB_CNT_W'(br_age) + ROB_CNT_W'(1) - ROB_CNT_W'(ret_n);
      end else begin
        tail_q <= tail_q + (issue ? ROB_W'(grp_u) : '0);
        cnt_q <= cnt_q + (issue ? ROB_CNT_W'(grp_u) : '0) - ROB_CNT_W'(ret_n);
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      retire_count_q <= '0;
      retire_pc_q <= '0;
      flush_q <= 1'b0;
    end else begin
      retire_count_q <= ret_n;
      if (ret_n != '0) begin
        retire_pc_q <= rob_uop[head_q].pc;
      end
      flush_q <= br_flush;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // data prefetch into the second-level cache: sequential line streams

  assign dline = dmiss_addr[ADDR_W-1:LINE_OFS_W];

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      last_line_q <= '0;
      l2_pf_q <= '0;
    end else begin
      l2_pf_q.valid <= 1'b0;
      if (dmiss_valid) begin
        last_line_q <= dline;
        if (dline == last_line_q + LINE_W'(1)) begin
          l2_pf_q.valid <= 1'b1;
          l2_pf_q.addr <= {dline + LINE_W'(1), {LINE_OFS_W{1'b0}}};
        end else if (dline == last_line_q - LINE_W'(1)) begin
          l2_pf_q.valid <= 1'b1;
          l2_pf_q.addr <= {dline - LINE_W'(1), {LINE_OFS_W{1'b0}}};
        end
      end
    end
  end

  assign ifill_req = ifill_req_q;
  assign l2_prefetch = l2_pf_q;
  assign retire_count = retire_count_q;
  assign retire_pc = retire_pc_q;
  assign flush_pulse = flush_q;
endmodule : scp_core
`default_nettype wire

/* verification/scp_core_asserts.sv */
// port assertions of the core instruction pipeline
`timescale 1ns/10ps
`default_nettype none
module scp_core_asserts (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // fill and prefetch
  input wire scp_pkg::scp_req_type ifill_req,
  input wire logic ifill_valid,
  input wire logic [scp_pkg::BLOCK_BITS-1:0] ifill_data,
  input wire logic dmiss_valid,
  input wire logic [scp_pkg::ADDR_W-1:0] dmiss_addr,
  input wire scp_pkg::scp_req_type l2_prefetch,
  // retirement
  input wire logic [scp_pkg::RET_W-1:0] retire_count,
  input wire logic [scp_pkg::ADDR_W-1:0] retire_pc,
  input wire logic flush_pulse
);
  import scp_pkg::*;
  logic pend_q;
  logic seen_q;
  logic fill_q;
  logic lok_q;
  logic [LINE_W-1:0] line_q;
  logic up;
  logic dn;
  assign up = lok_q && (dmiss_addr[31:6] == line_q + 26'h1);
  assign dn = lok_q && (dmiss_addr[31:6] == line_q - 26'h1);
  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pend_q <= 1'b0;
      seen_q <= 1'b0;
      fill_q <= 1'b0;
    end else begin
      if (ifill_req.valid) begin
        pend_q <= 1'b1;
        seen_q <= 1'b1;
      end else if (ifill_valid) begin
        pend_q <= 1'b0;
      end
      if (ifill_valid && pend_q) begin
        fill_q <= 1'b1;
      end
    end
  end
  // last miss line, kept even when no prefetch follows
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      lok_q <= 1'b0;
      line_q <= 26'h0;
    end else if (dmiss_valid) begin
      lok_q <= 1'b1;
      line_q <= dmiss_addr[31:6];
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  a_fill_aligned: assert property (ifill_req.valid |-> ifill_req.addr[3:0] == 4'h0)
    else $error("fill address not block aligned");
  a_one_outstanding: assert property (ifill_req.valid |-> !pend_q)
    else $error("second fill request before answer");
  a_fill_addr_holds: assert property (!ifill_req.valid |-> $stable(ifill_req.addr))
    else $error("fill address moved without request");
  a_first_fetch: assert property (ifill_req.valid && !seen_q |->
    ifill_req.addr == RESET_PC)
    else $error("first fill not at reset pc");
  a_pf_up: assert property (dmiss_valid && up |=> l2_prefetch.valid &&
    l2_prefetch.addr[31:6] == $past(dmiss_addr[31:6]) + 26'h1)
    else $error("no forward prefetch");
  a_pf_down: assert property (dmiss_valid && dn |=> l2_prefetch.valid &&
    l2_prefetch.addr[31:6] == $past(dmiss_addr[31:6]) - 26'h1)
    else $error("no backward prefetch");
  a_pf_none: assert property (dmiss_valid && !up && !dn |=> !l2_prefetch.valid)
    else $error("prefetch on non adjacent miss");
  a_pf_cause: assert property (l2_prefetch.valid |-> $past(dmiss_valid) &&
    l2_prefetch.addr[5:0] == 6'h0)
    else $error("prefetch without miss or unaligned");
  a_flush_single: assert property (flush_pulse |=> !flush_pulse)
    else $error("flush pulse too long");
  a_retire_pc_cause: assert property (!$stable(retire_pc) |-> retire_count != 2'h0)
    else $error("retire pc moved without retirement");
  a_retire_after_fill: assert property (retire_count != 2'h0 |-> fill_q)
    else $error("retirement before any fill");
  c_prefetch: cover property (l2_prefetch.valid);
  c_flush: cover property (flush_pulse);
  c_retire_three: cover property (retire_count == 2'h3);
endmodule : scp_core_asserts
`default_nettype wire

/* verification/scp_mem_model.sv */
// instruction memory model answering block fills
`timescale 1ns/10ps
`default_nettype none
module scp_mem_model #(
  parameter logic [31:0] LIMIT = 32'h0000_0040
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // block fill
  input wire scp_pkg::scp_req_type ifill_req,
  output logic ifill_valid,
  output logic [scp_pkg::BLOCK_BITS-1:0] ifill_data
);
  import scp_pkg::*;
  localparam logic [3:0] MIX [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h9, 4'h0};
  logic busy_q;
  logic slow_q;
  logic [1:0] wait_q;
  logic [31:0] addr_q;
  // two mixed blocks, a mispredicted forward branch to offset 14, then nothing
  function automatic scp_insn_type prog(input logic [31:0] a);
    scp_insn_type i;
    i = '0;
    i.imm = 10'h3;
    i.cls = MIX[a[3:1]];
    if (a[5:4] == 2'h2) begin
      i.cls = (a[3:1] < 3'h5) ? CLS_ALU : (a[3:1] == 3'h5) ? CLS_BR : CLS_CPLX;
      if (a[3:1] == 3'h5) begin
        i.taken = 1'b1;
        i.imm = 10'h00a;
      end
    end
    if (a[5:4] == 2'h3) begin
      i.cls = (a[3:1] == 3'h7) ? CLS_ALU : CLS_CPLX;
    end
    return i;
  endfunction : prog
  //////////////////////////////////////////////////////////////////////////////
  // answers alternate prompt and slow; blocks at or above the limit never answer
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      busy_q <= 1'b0;
      slow_q <= 1'b0;
      wait_q <= 2'h0;
      addr_q <= 32'h0;
      ifill_valid <= 1'b0;
      ifill_data <= 128'h0;
    end else begin
      ifill_valid <= 1'b0;
      ifill_data <= ~ifill_data;
      if (ifill_req.valid) begin
        busy_q <= 1'b1;
        addr_q <= ifill_req.addr;
        wait_q <= slow_q ? 2'h2 : 2'h0;
        slow_q <= ~slow_q;
      end else if (busy_q && addr_q < LIMIT) begin
        if (wait_q != 2'h0) begin
          wait_q <= wait_q - 2'h1;
        end else begin
          busy_q <= 1'b0;
          ifill_valid <= 1'b1;
          for (int k = 0; k < 8; k++) begin
            ifill_data[16*k +: 16] <= prog(addr_q + 32'(2 * k));
          end
        end
      end
    end
  end
endmodule : scp_mem_model
`default_nettype wire

/* verification/scp_core_tb_top.sv */
// self-checking bench of the core instruction pipeline
`timescale 1ns/10ps
`default_nettype none
module scp_core_tb_top;
  import scp_pkg::*;
  localparam logic [31:0] MA [5] = '{32'h4000, 32'h4040, 32'h4000, 32'h9000, 32'h8fc4};
  localparam logic [31:0] PA [5] = '{32'h0, 32'h4080, 32'h3fc0, 32'h0, 32'h8f80};
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic dmiss_valid = 1'b0;
  logic [31:0] dmiss_addr = 32'h0;
  scp_req_type ifill_req;
  scp_req_type l2_prefetch;
  logic ifill_valid;
  logic [127:0] ifill_data;
  logic [1:0] retire_count;
  logic [31:0] retire_pc;
  logic flush_pulse;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int ret_sum = 0;
  int flush_cnt = 0;
  logic [31:0] reqs [$];
  always #25 mclk = ~mclk;
  //////////////////////////////////////////////////////////////////////////////
  scp_core u_scp_core (.mclk(mclk), .reset(reset), .ifill_req(ifill_req),
    .ifill_valid(ifill_valid), .ifill_data(ifill_data), .dmiss_valid(dmiss_valid),
    .dmiss_addr(dmiss_addr), .l2_prefetch(l2_prefetch), .retire_count(retire_count),
    .retire_pc(retire_pc), .flush_pulse(flush_pulse));
  scp_mem_model u_scp_mem_model (.mclk(mclk), .reset(reset), .ifill_req(ifill_req),
    .ifill_valid(ifill_valid), .ifill_data(ifill_data));
  // the timeout also sits here; the whole run needs only a few hundred cycles
  always @(posedge mclk) begin
    cycles++;
    if (!reset) begin
      ret_sum += retire_count;
      flush_cnt += flush_pulse;
      if (ifill_req.valid) begin
        reqs.push_back(ifill_req.addr);
      end
    end
    if (cycles == 20000) begin
      err_count++;
      end_of_test();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic end_of_test();
    if (err_count == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test
  // counters are cleared while reset is high, so the monitor never races them
  task automatic do_reset(input int n);
    @(posedge mclk);
    reset <= 1'b1;
    repeat (n) @(posedge mclk);
    ret_sum = 0;
    flush_cnt = 0;
    reqs.delete();
    reset <= 1'b0;
  endtask : do_reset
  // reset in mid-run, then the whole program until the fill at 0x40 stalls it
  task automatic t_program();
    int n;
    int idle;
    do_reset(2);
    n = 0;
    idle = 0;
    while (reqs.size() < 5 && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    while (idle < 40 && n < 3000) begin
      @(posedge mclk);
      #1;
      idle = (retire_count === 2'h0) ? idle + 1 : 0;
      n++;
    end
    check("fill count", reqs.size(), 5);
    for (int k = 0; k < 5 && k < reqs.size(); k++) begin
      check("fill addr", reqs[k], 32'(k * 16));
    end
    check("retired", ret_sum, 31);
    check("flushes", flush_cnt, 1);
    // the last uop to retire is the one at the corrected branch target
    check("retire pc", retire_pc, 32'h0000_003e);
  endtask : t_program
  // back-to-back misses: first, forward, backward, far, backward
  task automatic t_prefetch();
    for (int i = 0; i <= 5; i++) begin
      @(posedge mclk);
      dmiss_valid <= (i < 5);
      if (i < 5) begin
        dmiss_addr <= MA[i];
      end
      if (i > 0) begin
        #1;
        check("pf valid", l2_prefetch.valid, PA[i-1] != 32'h0);
        if (PA[i-1] != 32'h0) begin
          check("pf addr", l2_prefetch.addr, PA[i-1]);
        end
      end
    end
  endtask : t_prefetch
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    repeat (20) @(posedge mclk);
    t_program();
    t_prefetch();
    end_of_test();
  end
endmodule : scp_core_tb_top
bind scp_core scp_core_asserts u_scp_core_asserts (.mclk(mclk), .reset(reset),
  .ifill_req(ifill_req), .ifill_valid(ifill_valid), .ifill_data(ifill_data),
  .dmiss_valid(dmiss_valid), .dmiss_addr(dmiss_addr), .l2_prefetch(l2_prefetch),
  .retire_count(retire_count), .retire_pc(retire_pc), .flush_pulse(flush_pulse));
`default_nettype wire
